// ---- rtl/adcsq_top.sv ----
// serial control, sequencer and power modes of a four-input converter
// assumes i_sclk idles high; logic on it sees edges only inside frames
module adcsq_top
    import adcsq_pkg::*;
(
    // system clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // serial link
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_din,
    output logic o_dout,
    output logic o_dout_oe,
    // converter core
    input wire logic [11:0] i_result,
    output logic [1:0] o_mux_sel,
    output logic o_hold,
    output logic o_range_one_ref,
    output logic o_twos_comp,
    output logic o_powered,
    output logic o_sample,
    // status on system clock
    output adcsq_stat_s o_stat
);
    //==========================================================
    // reset release
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end
    //==========================================================
    // link domain: frame counter on falling serial edges
    // chip-select high clears the frame asynchronously, since sclk may stop
    logic [4:0] edge_q;
    logic [11:0] shift_q;
    logic [11:0] ctrl_q;
    logic [1:0] conv_chan_q;
    logic [1:0] seq_chan_q;
    logic seq_run_q;
    logic track_q;
    logic woke_q;
    logic [15:0] out_q;
    logic oe_q;
    logic frame_done_q;
    logic [11:0] load_word;
    logic done_edge;
    logic load_now;
    logic [11:0] pend_q;
    logic pend_wr_q;
    logic seq_prog;
    logic seq_stop;
    logic [1:0] last_chan;
    logic [1:0] cur_pwr;
    logic [1:0] next_chan;
    logic [1:0] start_chan;
    assign load_word = {shift_q[10:0], i_din};
    assign done_edge = (edge_q == ADCSQ_EDGE_LAST - 5'h0_001);
    assign load_now = (edge_q == ADCSQ_EDGE_LOAD - 5'h0_001);
    assign last_chan = {ctrl_q[ADCSQ_BIT_ADDR_HI], ctrl_q[ADCSQ_BIT_ADDR_LO]};
    // a write with sequence bits 1,0 leaves a running sequence alone
    assign seq_prog = pend_wr_q & pend_q[ADCSQ_BIT_SEQ_HI] & pend_q[ADCSQ_BIT_SEQ_LO];
    assign seq_stop = pend_wr_q & ~(pend_q[ADCSQ_BIT_SEQ_HI] & ~pend_q[ADCSQ_BIT_SEQ_LO]);
    assign cur_pwr = {ctrl_q[ADCSQ_BIT_PWR_HI], ctrl_q[ADCSQ_BIT_PWR_LO]};
    // channel for the frame being started
    assign start_chan = seq_run_q ? seq_chan_q :
        {ctrl_q[ADCSQ_BIT_ADDR_HI], ctrl_q[ADCSQ_BIT_ADDR_LO]};
    assign next_chan = (seq_chan_q == {ctrl_q[ADCSQ_BIT_ADDR_HI], ctrl_q[ADCSQ_BIT_ADDR_LO]})
        ? 2'h0 : seq_chan_q + 2'h1;
    // shadow register takes the word at edge twelve, committed at sixteen
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            edge_q <= 5'h0_000;
            shift_q <= 12'h0_000;
        end else begin
            if (edge_q != ADCSQ_EDGE_LAST) begin
                edge_q <= edge_q + 5'h0_001;
            end
            if (edge_q < ADCSQ_EDGE_LOAD) begin
                shift_q <= load_word;
            end
        end
    end
    always_ff @(negedge i_sclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pend_q <= ADCSQ_CTRL_RST;
            pend_wr_q <= 1'b0;
        end else if (load_now) begin
            pend_q <= load_word;
            pend_wr_q <= load_word[ADCSQ_BIT_WRITE];
        end
    end
    // commit only on a full frame; an early chip-select rise leaves it untouched
    // done_edge is never true while deselected, since the counter is held clear
    always_ff @(negedge i_sclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= ADCSQ_CTRL_RST;
        end else if (done_edge && pend_wr_q) begin
            // write bit clear keeps every field, power mode included
            ctrl_q <= pend_q;
        end
    end
    always_ff @(negedge i_sclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            frame_done_q <= 1'b0;
        end else if (done_edge) begin
            frame_done_q <= ~frame_done_q;
        end
    end
    always_ff @(negedge i_sclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            seq_run_q <= 1'b0;
        end else if (done_edge && seq_prog) begin
            seq_run_q <= 1'b1;
        end else if (done_edge && seq_stop) begin
            seq_run_q <= 1'b0;
        end
    end
    always_ff @(negedge i_sclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            seq_chan_q <= 2'h0;
        end else if (done_edge && seq_prog) begin
            seq_chan_q <= 2'h0;
        end else if (done_edge && seq_run_q && !seq_stop) begin
            seq_chan_q <= next_chan;
        end
    end
    // output word and track-and-hold, per frame
    logic full_off;
    assign full_off = (cur_pwr == ADCSQ_PWR_FULL_OFF);
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            out_q <= 16'h0_000;
            // armed while deselected so the bus leaves three-state at chip-select fall, except in full shutdown
            oe_q <= 1'b1;
            track_q <= 1'b1;
            conv_chan_q <= 2'h0;
        end else if (edge_q == 5'h0_000) begin
            conv_chan_q <= start_chan;
            // first zero already shows from the cleared register, so load one place up
            out_q <= {1'b0, start_chan, i_result, 1'b0};
            oe_q <= ~full_off;
            track_q <= 1'b0;
        end else begin
            out_q <= {out_q[14:0], 1'b0};
            if (edge_q == ADCSQ_EDGE_TRACK - 5'h0_001) begin
                track_q <= 1'b1;
            end
            if (done_edge) begin
                oe_q <= 1'b0;
            end
        end
    end
    // first zero shows at chip-select fall, later bits follow on falling edges
    assign o_dout = out_q[15];
    assign o_dout_oe = oe_q & ~i_cs_n & ~full_off;
    assign o_mux_sel = (edge_q == 5'h0_000) ? start_chan : conv_chan_q;
    assign o_hold = ~i_cs_n & ~track_q;
    //==========================================================
    // power state, re-evaluated at each frame end
    // auto mode sleeps after every frame and wakes at chip-select fall
    always_ff @(posedge i_cs_n or negedge rst_n_q) begin
        if (!rst_n_q) begin
            woke_q <= 1'b1;
        end else begin
            woke_q <= (cur_pwr == ADCSQ_PWR_NORMAL);
        end
    end
    logic awake;
    assign awake = woke_q | (!i_cs_n && cur_pwr == ADCSQ_PWR_AUTO);
    assign o_powered = awake;
    assign o_range_one_ref = ctrl_q[ADCSQ_BIT_RANGE];
    assign o_twos_comp = ctrl_q[ADCSQ_BIT_CODING];
    assign o_sample = ~i_cs_n;
    //==========================================================
    // status crossing into the system clock domain
    adcsq_stat_s stat_link;
    logic [2:0] done_sync_q;
    assign stat_link.chan = conv_chan_q;
    assign stat_link.range_one_ref = ctrl_q[ADCSQ_BIT_RANGE];
    assign stat_link.twos_comp = ctrl_q[ADCSQ_BIT_CODING];
    assign stat_link.pwr = adcsq_pwr_e'(cur_pwr);
    assign stat_link.seq_run = seq_run_q;
    // settled power state; woke_q only follows at the later chip-select rise
    assign stat_link.powered = (cur_pwr == ADCSQ_PWR_NORMAL);
    logic done_s;
    adcsq_sync #(.W(1)) u_done_sync (
        .i_clk(i_mclk),
        .i_rst_n(rst_n_q),
        .i_d(frame_done_q),
        .o_q(done_s)
    );
    // status word holds from the frame toggle until chip-select rise clears chan, so sampling soon after the toggle is safe
    always_ff @(posedge i_mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            done_sync_q <= 3'h0;
            o_stat <= '0;
        end else begin
            done_sync_q <= {done_sync_q[1:0], done_s};
            if (done_sync_q[2] != done_sync_q[1]) begin
                o_stat <= stat_link;
            end
        end
    end
endmodule : adcsq_top

// ---- rtl/adcsq_pkg.sv ----
// constants, types and modes for the four-input converter control block
// assumes a serial host driving chip-select, serial clock and data-in
//==========================================================
// package
package adcsq_pkg;
    localparam int ADCSQ_CTRL_W = 12;
    localparam int ADCSQ_WORD_W = 16;
    // control word bit positions, msb first on the wire
    localparam int ADCSQ_BIT_WRITE = 11;
    localparam int ADCSQ_BIT_SEQ_HI = 10;
    localparam int ADCSQ_BIT_SEQ_LO = 3;
    localparam int ADCSQ_BIT_ADDR_HI = 7;
    localparam int ADCSQ_BIT_ADDR_LO = 6;
    localparam int ADCSQ_BIT_PWR_HI = 5;
    localparam int ADCSQ_BIT_PWR_LO = 4;
    localparam int ADCSQ_BIT_RANGE = 1;
    localparam int ADCSQ_BIT_CODING = 0;
    localparam logic [11:0] ADCSQ_CTRL_RST = 12'h0_030;
    localparam logic [4:0] ADCSQ_EDGE_TRACK = 5'h0_00e;
    localparam logic [4:0] ADCSQ_EDGE_LAST = 5'h0_010;
    localparam logic [4:0] ADCSQ_EDGE_LOAD = 5'h0_00c;
    typedef enum logic [1:0] {
        ADCSQ_PWR_FULL_OFF = 2'h2,
        ADCSQ_PWR_AUTO = 2'h1,
        ADCSQ_PWR_NORMAL = 2'h3,
        ADCSQ_PWR_RSVD = 2'h0
    } adcsq_pwr_e;
    typedef struct packed {
        logic [1:0] chan;
        logic range_one_ref;
        logic twos_comp;
        adcsq_pwr_e pwr;
        logic seq_run;
        logic powered;
    } adcsq_stat_s;
endpackage : adcsq_pkg

// ---- rtl/adcsq_sync.sv ----
// two flip-flop level synchroniser
// assumes the input is asynchronous to i_clk
module adcsq_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            o_q <= '0;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule : adcsq_sync

// ---- dv/adcsq_assertions.sv ----
// checker for the converter control block, top-level ports only
// assumes i_sclk idles high and toggles only inside frames
module adcsq_assertions
    import adcsq_pkg::*;
(
    // clocks and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // serial link
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic o_dout,
    input wire logic o_dout_oe,
    // converter core and status
    input wire logic o_hold,
    input wire logic o_sample,
    input wire logic o_range_one_ref,
    input wire logic o_twos_comp,
    input wire adcsq_stat_s o_stat
);
    //==========================================================
    // falling-edge count within a frame, cleared while deselected
    logic [4:0] n_q;
    always_ff @(negedge i_sclk or posedge i_cs_n or negedge i_arst_n) begin
        if (!i_arst_n || i_cs_n) begin
            n_q <= 5'h00;
        end else if (n_q != 5'h1f) begin
            n_q <= n_q + 5'h01;
        end
    end
    //==========================================================
    // properties, sampled on the system clock
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    a_sample_cs: assert property (o_sample == !i_cs_n)
        else $error("sample strobe does not follow chip-select");
    a_idle_undriven: assert property (i_cs_n |-> !o_dout_oe)
        else $error("data out driven while deselected");
    a_first_zero: assert property ($fell(i_cs_n) && o_dout_oe |-> !o_dout)
        else $error("first output bit is not zero");
    a_oe_release: assert property (n_q >= 5'h10 |-> !o_dout_oe)
        else $error("data out still driven after sixteenth edge");
    a_track_resume: assert property ((n_q == 5'h0e || n_q == 5'h0f) &&
        o_stat.pwr != ADCSQ_PWR_FULL_OFF |-> !o_hold) else $error("still holding late in frame");
    a_normal_drive: assert property (!i_cs_n && n_q < 5'h10 &&
        o_stat.pwr == ADCSQ_PWR_NORMAL |-> o_dout_oe) else $error("normal frame not driven");
    a_off_silent: assert property (o_stat.pwr == ADCSQ_PWR_FULL_OFF |-> !o_dout_oe)
        else $error("data out driven in full shutdown");
    a_cfg_hold: assert property (i_cs_n [*4] |=> $stable(o_range_one_ref) &&
        $stable(o_twos_comp)) else $error("configuration changed between frames");
    c_full_frame: cover property (n_q == 5'h10);
    c_silent_frame: cover property ($fell(i_cs_n) && !o_dout_oe);
    c_seq_running: cover property (o_stat.seq_run);
endmodule : adcsq_assertions

bind adcsq_top adcsq_assertions u_chk (.i_mclk, .i_arst_n, .i_sclk, .i_cs_n, .o_dout,
    .o_dout_oe, .o_hold, .o_sample, .o_range_one_ref, .o_twos_comp, .o_stat);

// ---- dv/adcsq_host.sv ----
// host controller model: chip-select, 48 ns serial clock, control word out
// assumes the caller waits for each frame task, which ends with its own gap; clock stands high between frames
module adcsq_host (
    // serial link
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_din,
    input wire logic i_dout,
    input wire logic i_dout_oe,
    // captured word, drive flags {all, any}, toggles per full frame
    output logic [15:0] o_rx,
    output logic [1:0] o_drv,
    output logic o_done
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {o_sclk, o_cs_n, o_din, o_done} = 4'b1100;
    end
    task automatic frame(input logic [11:0] cw, input int n);
        logic [15:0] rx;
        logic all;
        logic any;
        #0.7;
        o_cs_n = 0;
        {all, any} = 2'b10;
        for (int i = 0; i < n; i++) begin
            o_din = (i < 12) ? cw[11-i] : ~o_din;
            #24;
            // a released line reads as the inverse, so a late drive shows up as bad data
            rx[15-i] = i_dout_oe ? i_dout : ~i_dout;
            all &= i_dout_oe;
            any |= i_dout_oe;
            o_sclk = 0;
            #24;
            o_sclk = 1;
        end
        #12;
        o_cs_n = 1;
        o_din = ~o_din;
        if (n == 16) begin
            {o_rx, o_drv, o_done} = {rx, all, any, ~o_done};
        end
        // cs fall spacing, quiet and wake intervals all covered by one gap
        #4300;
    endtask : frame
endmodule : adcsq_host

// ---- dv/testbench.sv ----
// self-checking bench for the converter control block
// assumes the host model is the only driver of the serial link
module testbench
    import adcsq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_mclk = 0, i_arst_n = 0, sclk, cs_n, din, done, o_dout, o_dout_oe, o_hold;
    logic o_range_one_ref, o_twos_comp, o_powered, o_sample, rg = 0, cd = 0, sq_on = 0;
    logic [11:0] i_result = 12'h000;
    logic [1:0] o_mux_sel, drv, a_q = 2'h0, p_q = 2'h3, sq_ch = 2'h0, st_ch = 2'h0;
    logic [15:0] rx;
    logic [17:0] e;
    logic [17:0] q[$];
    adcsq_stat_s o_stat;
    int fail_count = 0, checked = 0, cyc = 0;
    always #2 i_mclk = ~i_mclk;
    adcsq_top uut (.i_mclk, .i_arst_n, .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din), .o_dout,
        .o_dout_oe, .i_result, .o_mux_sel, .o_hold, .o_range_one_ref, .o_twos_comp,
        .o_powered, .o_sample, .o_stat);
    adcsq_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(o_dout),
        .i_dout_oe(o_dout_oe), .o_rx(rx), .o_drv(drv), .o_done(done));
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize;
        if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    //==========================================================
    // one frame: note the expected word, run it, update the model
    task automatic xfer(input logic w, sh, sl, input logic [1:0] a, p, input logic r, c,
        input int n);
        logic [1:0] ch;
        ch = sq_on ? sq_ch : a_q;
        @(posedge i_mclk);
        #1 i_result = 12'($urandom);
        if (n == 16) q.push_back({(p_q == 2'h2) ? 2'b00 : 2'b11, 2'b00, ch, i_result});
        host.frame({w, sh, 2'b00, a, p, sl, 1'b0, r, c}, n);
        if (n == 16) begin
            st_ch = ch;
            if (sq_on) sq_ch = (sq_ch == a_q) ? 2'h0 : sq_ch + 2'h1;
            if (w) begin
                {a_q, p_q, rg, cd} = {a, p, r, c};
                if (sh && sl) {sq_on, sq_ch} = 3'b100;
                else if (!(sh && !sl)) sq_on = 0;
            end
        end
        chk({o_range_one_ref, o_twos_comp, o_powered, o_stat.pwr, o_stat.seq_run, o_dout_oe},
            {rg, cd, p_q == 2'h3, p_q, sq_on, 1'b0});
        chk({o_mux_sel, o_stat.chan, o_stat.range_one_ref, o_stat.twos_comp, o_stat.powered},
            {sq_on ? sq_ch : a_q, st_ch, rg, cd, p_q == 2'h3});
    endtask : xfer
    //==========================================================
    // result watcher: oldest note against each completed frame
    always @(done) if ($time > 0) begin
        e = (q.size() != 0) ? q.pop_front() : 18'h3_ffff;
        if (e[17:16] == 2'b00) chk({drv, 16'h0000}, {e[17:16], 16'h0000});
        else chk({drv, rx}, e);
    end
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            $display("MISMATCH at %0t: timeout", $time);
            summarize();
        end
    end
    initial begin
        void'($urandom(63847));
        repeat (5) @(posedge i_mclk);
        #1 i_arst_n = 1;
        repeat (4) @(posedge i_mclk);
        chk({o_range_one_ref, o_twos_comp, o_powered, o_dout_oe}, 4'b0010);
        for (int a = 0; a < 4; a++) xfer(1, 0, 0, 2'(a), 2'h3, 1'($urandom), 1'($urandom), 16);
        xfer(0, 1, 1, 2'h2, 2'h2, 1, 1, 16);
        xfer(1, 1, 0, 2'h1, 2'h2, 1, 1, 10);
        xfer(1, 1, 1, 2'h2, 2'h3, 0, 1, 16);
        repeat (4) xfer(0, 0, 0, 2'h0, 2'h0, 0, 0, 16);
        xfer(1, 1, 0, 2'h2, 2'h3, 1, 0, 16);
        xfer(0, 0, 0, 2'h0, 2'h0, 0, 0, 16);
        xfer(1, 0, 0, 2'h1, 2'h3, 0, 0, 16);
        xfer(0, 1, 1, 2'h3, 2'h1, 1, 1, 16);
        xfer(1, 0, 0, 2'h1, 2'h2, 0, 0, 16);
        xfer(0, 0, 0, 2'h0, 2'h3, 0, 0, 16);
        xfer(1, 0, 0, 2'h1, 2'h3, 0, 0, 16);
        xfer(1, 0, 0, 2'h2, 2'h1, 0, 0, 16);
        xfer(0, 0, 0, 2'h0, 2'h0, 0, 0, 16);
        xfer(1, 0, 0, 2'h3, 2'h3, 1, 1, 16);
        summarize();
    end
endmodule : testbench
